/* bench/tbrd_far_model.sv */
// far side: other boards on the trigger lines, the star controller
`default_nettype none
module tbrd_far_model
   import tbrd_pkg::*;
(
   input  wire logic            hclk,
   input  wire logic [NBUS-1:0] dut_out,  // block drive levels
   input  wire logic [NBUS-1:0] dut_oe,   // block drive enables
   input  wire logic [NBUS-1:0] far_oe,   // lines this board drives
   input  wire logic [NBUS-1:0] far_val,  // levels it drives
   input  wire logic            star_val, // controller star level
   output logic      [NBUS-1:0] line,     // resolved line levels
   output logic                 star_in   // star wire
);
   timeunit 1ns;
   timeprecision 1ns;
   // released lines wander, so a stale value never looks valid
   logic [NBUS-1:0] float_r = '0;
   always_ff @(posedge hclk) float_r <= ~float_r;
   // block first, then this board, else the wandering pattern
   assign line = (dut_oe & dut_out) | (~dut_oe & far_oe & far_val)
               | (~dut_oe & ~far_oe & float_r);
   assign star_in = star_val;
endmodule // tbrd_far_model
`default_nettype wire

/* bench/tbrd_top_chk.sv */
// port checker for the trigger routing and debounce block
`default_nettype none
module tbrd_top_chk
   import tbrd_pkg::*;
#(
   parameter int N_LONG = N_2MS // kept in step with the block
)
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic [31:0]       hrdata,
   input wire logic [NBUS-1:0]   itb_in,
   input wire logic [NBUS-1:0]   itb_out,
   input wire logic [NBUS-1:0]   itb_oe,
   input wire logic [NFUNC-1:0]  pfl_out,
   input wire logic [NFUNC-1:0]  pfl_oe,
   input wire logic [NINT-1:0]   int_src,
   input wire logic [NDEST-1:0]  dest_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ***************************************************
   // shadow of the registers, rebuilt from bus traffic
   // ***************************************************
   logic       ap_w, ap_r; // address phase seen
   logic [7:0] ap_a;       // its offset
   logic [7:0] dir_s;      // drive enables
   logic [4:0] osel_s;     // source of line 0
   logic [5:0] dcfg_s;     // config of destination 0
   logic [1:0] fcfg_s;     // filter of line 0
   logic [3:0] fsel_s;     // route of function line 0
   logic [3:0] age;        // cycles since a write, saturates
   logic [7:0] hist;       // past samples of line 0
   logic       inv;        // destination 0 inverts
   logic       lvl0;       // destination 0 is line 0, level mode
   assign inv  = dcfg_s[DC_INV];
   assign lvl0 = dcfg_s[3:0] == 4'h1 && !dcfg_s[DC_EDGE];
   // shadow registers change at the same edge as the block's
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {ap_w, ap_r, ap_a, dir_s, osel_s, dcfg_s, fcfg_s, fsel_s, age, hist} <= '0;
      else
      begin
         ap_w <= hsel && hready && htrans[1] && hwrite;
         ap_r <= hsel && hready && htrans[1] && !hwrite;
         ap_a <= haddr[7:0];
         hist <= {hist[6:0], itb_in[0]};
         age  <= (age == 4'hF) ? age : age + 4'h1;
         if (ap_w)
         begin
            age <= 4'h0;
            if (ap_a == ADDR_DIR) dir_s <= hwdata[7:0];
            if (ap_a == ADDR_OSEL0) osel_s <= hwdata[4:0];
            if (ap_a == ADDR_DCFG0) dcfg_s <= hwdata[5:0];
            if (ap_a == ADDR_FCFG) fcfg_s <= hwdata[1:0];
            if (ap_a == ADDR_FSEL) fsel_s <= hwdata[3:0];
         end
      end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_ready; $past(hresetn) |-> hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   property p_idle; !ap_r |-> hrdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("hrdata not zero");
   property p_rd_dir; ap_r && ap_a == ADDR_DIR |-> hrdata == {24'h0, dir_s}; endproperty
   a_rd_dir: assert property (p_rd_dir) else $error("enable readback");
   property p_oe; age != 4'h0 |-> itb_oe == dir_s; endproperty
   a_oe: assert property (p_oe) else $error("drive enables differ");
   property p_src;
      age > 4'h9 && itb_oe[0] && osel_s < SRC_FUNC0 |-> itb_out[0] ==
         ($past(int_src[osel_s]) ^ (osel_s == SRC_AI_CONV || osel_s == SRC_AO_SAMPLE));
   endproperty
   a_src: assert property (p_src) else $error("line 0 source");
   property p_off; age > 4'h9 && lvl0 && fcfg_s == FILT_OFF |-> dest_out[0] == (hist[3] ^ inv);
   endproperty
   a_off: assert property (p_off) else $error("unfiltered path");
   property p_filt; age > 4'h9 && lvl0 && fcfg_s == FILT_125NS && $changed(dest_out[0])
      |-> hist[7:3] == {5{dest_out[0] ^ inv}}; endproperty
   a_filt: assert property (p_filt) else $error("filter passed early");
   property p_fwd; age > 4'h9 && fsel_s == 4'h8 |-> pfl_oe[0] && pfl_out[0] == hist[2];
   endproperty
   a_fwd: assert property (p_fwd) else $error("function forward");
   property p_rst; $rose(hresetn) |-> dest_out == '0 && itb_oe == '0 && pfl_oe == '0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule // tbrd_top_chk
bind tbrd_top tbrd_top_chk #(.N_LONG(N_LONG)) tbrd_top_chk_inst (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .itb_in(itb_in), .itb_out(itb_out), .itb_oe(itb_oe), .pfl_out(pfl_out),
   .pfl_oe(pfl_oe), .int_src(int_src), .dest_out(dest_out));
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the trigger routing and debounce block
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
   import tbrd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LONG = 20; // shortened longest filter count
   logic             hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, star_val = 0;
   logic             hready, hreadyout, hresp, star_in;
   assign hready = hreadyout; // the one slave sets the bus ready
   logic [31:0]      haddr = '0, hwdata = '0, hrdata;
   logic [1:0]       htrans = '0;
   logic [NBUS-1:0]  itb_line, itb_out, itb_oe, far_oe = '0, far_val = '0;
   logic [NFUNC-1:0] pfl_in = '0, pfl_out, pfl_oe;
   logic [NINT-1:0]  int_src = '0;
   logic [NDEST-1:0] dest_out;
   int               err_count = 0, n_tests = 0, cyc = 0, n, pulses;
   tbrd_top #(.N_LONG(LONG)) tbrd_top_inst (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .itb_in(itb_line), .itb_out(itb_out), .itb_oe(itb_oe),
      .star_in(star_in), .pfl_in(pfl_in), .pfl_out(pfl_out), .pfl_oe(pfl_oe),
      .int_src(int_src), .dest_out(dest_out));
   tbrd_far_model tbrd_far_model_inst (.hclk(hclk), .dut_out(itb_out),
      .dut_oe(itb_oe), .far_oe(far_oe), .far_val(far_val), .star_val(star_val),
      .line(itb_line), .star_in(star_in));
   initial forever #25 hclk = ~hclk;
   // cut a hang short; the full run takes about 2100 cycles
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge hclk);
   endtask
   // one single AHB-Lite word transfer, entered just after an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1; hwrite <= w; htrans <= 2'h2; haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      `CHK(hresp, 1'b0)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   // lines 0 and 1 high for len cycles; which destinations saw it
   task automatic pulse(input int len, input logic [1:0] e);
      logic [1:0] seen;
      seen = 2'b00;
      for (int i = 0; i < 2 * len + 14; i++)
      begin
         far_val <= (i < len) ? 8'h03 : 8'h00;
         @(posedge hclk);
         seen |= dest_out[1:0];
      end
      `CHK(seen, e)
   endtask
   initial
   begin
      tick(20);
      hresetn <= 1'b1;
      tick(2);
      rd(ADDR_DIR, 32'h0);
      rd(ADDR_FCFG, 32'h0);
      rd(ADDR_DCFG0, 32'h0);
      rd(8'h30, 32'h0);
      wr(ADDR_DIR, 32'h1);
      rd(ADDR_DIR, 32'h1);
      tick(2);
      `CHK(itb_oe, 8'h01)
      // every source code onto line 0
      for (int c = 0; c < 26; c++)
      begin
         wr(ADDR_OSEL0, 32'(c));
         for (int v = 0; v < 2; v++)
         begin
            int_src <= {NINT{v[0]}};
            pfl_in <= {NFUNC{v[0]}};
            tick(6);
            `CHK(itb_out[0], v[0] ^ (c == SRC_AI_CONV || c == SRC_AO_SAMPLE))
         end
      end
      // every destination from a bus line, then star and function line
      wr(ADDR_DIR, 32'h0);
      far_oe <= 8'hFF;
      for (int d = 0; d < NDEST; d++)
      begin
         wr(ADDR_DCFG0 + 8'(4 * d), 32'(1 + d % 8));
         for (int v = 0; v < 2; v++)
         begin
            far_val <= {NBUS{v[0]}};
            tick(6);
            `CHK(dest_out[d], v[0])
         end
      end
      rd(ADDR_STAT, 32'h7EFF_7EFF);
      wr(ADDR_DCFG0 + 8'h04, 32'h9);
      wr(ADDR_DCFG0 + 8'h08, 32'hA);
      for (int v = 0; v < 2; v++)
      begin
         star_val <= v[0];
         pfl_in <= {NFUNC{v[0]}};
         tick(6);
         `CHK(dest_out[2:1], {2{v[0]}})
      end
      // polarity, then rising edge gives a single pulse
      far_val <= 8'h00;
      wr(ADDR_DCFG0, 32'h11);
      tick(6);
      `CHK(dest_out[0], 1'b1)
      wr(ADDR_DCFG0, 32'h21);
      tick(6);
      far_val <= 8'h01;
      pulses = 0;
      for (int i = 0; i < 12; i++)
      begin
         @(posedge hclk);
         pulses += int'(dest_out[0] === 1'b1);
      end
      `CHK(pulses, 1)
      // each filter setting on line 0; line 1 stays unfiltered
      wr(ADDR_DCFG0, 32'h01);
      wr(ADDR_DCFG0 + 8'h04, 32'h02);
      // line 0 was left high; every pulse must start from low
      far_val <= 8'h00;
      tick(6);
      for (int s = 1; s < 4; s++)
      begin
         wr(ADDR_FCFG, 32'(s));
         n = (s == 1) ? N_125NS : (s == 2) ? N_6US : LONG;
         pulse(n - 1, 2'b10);
         pulse(n + 2, 2'b11);
      end
      // bus to function line skips the long filter
      wr(ADDR_FSEL, 32'h8);
      far_val <= 8'h01;
      tick(4);
      `CHK({pfl_oe[0], pfl_out[0]}, 2'b11)
      far_val <= 8'h00;
      tick(4);
      `CHK(pfl_out[0], 1'b0)
      // second reset in mid-run clears the filter settings
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(2);
      rd(ADDR_FCFG, 32'h0);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire

/* logic/tbrd_filter.sv */
// one debounce filter: N equal samples before a level passes
`default_nettype none
module tbrd_filter
   import tbrd_pkg::*;
#(
   parameter int N_LONG = N_2MS
)
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       sample_en,
   input  wire logic       din,
   input  wire logic [1:0] setting,
   output logic            dout
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [CNT_W-1:0] cnt;   // consecutive differing samples
      logic             level; // level passed on
   } tbrd_filt_st_t;

   tbrd_filt_st_t s_r;   // registered state
   tbrd_filt_st_t s_nxt; // next state
   logic [CNT_W-1:0] need; // samples needed at this setting

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      s_nxt = s_r;
      unique case (setting)
         FILT_125NS : need = CNT_W'(N_125NS);
         FILT_6US   : need = CNT_W'(N_6US);
         FILT_2MS   : need = CNT_W'(N_LONG);
         default    : need = CNT_W'(1);
      endcase
      if (setting == FILT_OFF)
      begin
         // disabled: straight through, counter parked
         s_nxt.level = din;
         s_nxt.cnt   = '0;
      end
      else if (sample_en)
      begin
         if (din == s_r.level)
         begin
            // a glitch back restarts the run
            s_nxt.cnt = '0;
         end
         else if (s_r.cnt == need - CNT_W'(1))
         begin
            // N-th differing sample in a row, either direction
            s_nxt.level = din;
            s_nxt.cnt   = '0;
         end
         else
         begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign dout = s_r.level;

endmodule // tbrd_filter
`default_nettype wire

/* logic/tbrd_pkg.sv */
// constants shared by the trigger bus routing and debounce block
`default_nettype none
package tbrd_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NBUS  = 8;    // intercard trigger bus lines
   localparam int NFUNC = 6;    // programmable function lines
   localparam int NFILT = 15;   // bus lines, star, function lines
   localparam int NINT  = 20;   // internal timing sources
   localparam int NDEST = 26;   // timing input destinations
   localparam int STAR_IDX = 8; // star trigger in filter vector
   localparam int CNT_W = 17;   // debounce counter width

   // ************************************************************
   // timing
   // ************************************************************
   localparam int HCLK_HZ     = 20_000_000;
   localparam int FILT_CLK_HZ = 40_000_000;
   // hclk is slower than the filter clock, so it samples every cycle
   localparam int SAMPLE_DIV  = (HCLK_HZ >= 2 * FILT_CLK_HZ) ?
                                (HCLK_HZ / FILT_CLK_HZ) : 1;
   localparam int N_125NS = 5;       // samples, shortest setting
   localparam int N_6US   = 257;     // samples, middle setting
   localparam int N_2MS   = 101_800; // samples, longest setting

   // ************************************************************
   // filter settings
   // ************************************************************
   localparam logic [1:0] FILT_OFF   = 2'h0; // value after reset
   localparam logic [1:0] FILT_125NS = 2'h1;
   localparam logic [1:0] FILT_6US   = 2'h2;
   localparam logic [1:0] FILT_2MS   = 2'h3;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] ADDR_DIR   = 8'h00; // line drive enables
   localparam logic [7:0] ADDR_OSEL0 = 8'h04; // 8 source selects
   localparam logic [7:0] ADDR_FCFG  = 8'h24; // filter settings
   localparam logic [7:0] ADDR_FSEL  = 8'h28; // bus to function lines
   localparam logic [7:0] ADDR_STAT  = 8'h2C; // line levels
   localparam logic [7:0] ADDR_DCFG0 = 8'h40; // 26 destination cfgs
   localparam logic [7:0] ADDR_DEND  = 8'hA8; // first past last cfg

   // ************************************************************
   // source codes driven onto bus lines
   // ************************************************************
   localparam logic [4:0] SRC_AI_CONV   = 5'h02;
   localparam logic [4:0] SRC_AO_SAMPLE = 5'h05;
   localparam logic [4:0] SRC_FUNC0     = 5'h14;
   localparam logic [4:0] SRC_END       = 5'h1A;

   // ************************************************************
   // destination config fields and selector codes
   // ************************************************************
   localparam int DC_INV  = 4;          // polarity invert bit
   localparam int DC_EDGE = 5;          // edge mode bit
   localparam logic [3:0] DSEL_NONE = 4'h0; // value after reset
   localparam int FS_EN = 3;            // function route enable bit

endpackage
`default_nettype wire

/* logic/tbrd_top.sv */
// trigger bus routing and debounce with an AHB-Lite register slave
`default_nettype none

// Behaviour
// - each bus line selectable input or output
// - any listed internal source drives any line
// - conversion and sample clocks inverted onto bus
// - any bus line feeds any timing input
// - per destination polarity and edge or level
// - filter on every input, samples on tick
// - filter clock rate is forty megahertz; here filters sample every hclk cycle, 20 MHz
// - N equal samples pass a transition
// - settings 5, 257, 101800 samples or off
// - separate filter setting per input
// - all filters disabled after reset
// - jitter bounded by one sample period
// - function to bus routes skip filter
// - bus lines are backplane trigger lines
// - star trigger is input only
module tbrd_top
   import tbrd_pkg::*;
#(
   parameter int N_LONG = N_2MS // longest setting, samples
)
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic [NBUS-1:0]   itb_in,
   output logic [NBUS-1:0]        itb_out,
   output logic [NBUS-1:0]        itb_oe,
   input  wire logic              star_in,
   input  wire logic [NFUNC-1:0]  pfl_in,
   output logic [NFUNC-1:0]       pfl_out,
   output logic [NFUNC-1:0]       pfl_oe,
   input  wire logic [NINT-1:0]   int_src,
   output logic [NDEST-1:0]       dest_out
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [NFILT-1:0]           sync1;   // first stage, pins
      logic [NFILT-1:0]           sync2;   // second stage
      logic [7:0]                 div;     // sample divider
      logic                       tick;    // filter sample enable
      logic [NBUS-1:0]            dir;     // 1 = line is output
      logic [NBUS-1:0][4:0]       osel;    // source per line
      logic [NFILT-1:0][1:0]      fcfg;    // filter per input
      logic [NFUNC-1:0][3:0]      fsel;    // bus line per function
      logic [NDEST-1:0][5:0]      dcfg;    // destination configs
      logic [NDEST-1:0]           dlvl;    // last polarised level
      logic                       wr_pend; // write data phase due
      logic [7:0]                 wr_addr; // its byte address
      logic [31:0]                rdata;   // read data
      logic [NBUS-1:0]            bus_out;
      logic [NBUS-1:0]            bus_oe;
      logic [NFUNC-1:0]           fn_out;
      logic [NFUNC-1:0]           fn_oe;
      logic [NDEST-1:0]           dest;
   } tbrd_top_st_t;

   tbrd_top_st_t     s_r;   // registered state
   tbrd_top_st_t     s_nxt; // next state
   logic [NFILT-1:0] filt;  // debounced input levels

   // ************************************************************
   // functions
   // ************************************************************
   // level of one source code; unmapped codes give low
   function automatic logic src_pick(input logic [4:0] code,
                                     input logic [NINT-1:0] isrc,
                                     input logic [NFUNC-1:0] fraw);
      logic v;
      v = 1'b0;
      if (code < 5'(NINT))
      begin
         v = isrc[code];
         // clocks that sample on the falling edge go out inverted
         if (code == SRC_AI_CONV || code == SRC_AO_SAMPLE)
            v = ~v;
      end
      else if (code < SRC_END)
      begin
         // function input goes out unfiltered
         v = fraw[3'(code - SRC_FUNC0)];
      end
      return v;
   endfunction

   // register read mux, decoded from the updated copy
   // raw levels come in apart, from the second sync stage only
   function automatic logic [31:0] rd_reg(input logic [7:0] a,
                                          input tbrd_top_st_t st,
                                          input logic [NFILT-1:0] fl,
                                          input logic [NFILT-1:0] raw);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a[1:0] != 2'h0)
         d = 32'h0000_0000;
      else if (a == ADDR_DIR)
         d = {24'h00_0000, st.dir};
      else if (a >= ADDR_OSEL0 && a < ADDR_FCFG)
         d = {27'h000_0000, st.osel[3'((a - ADDR_OSEL0) >> 2)]};
      else if (a == ADDR_FCFG)
         d = {2'h0, st.fcfg};
      else if (a == ADDR_FSEL)
         d = {8'h00, st.fsel};
      else if (a == ADDR_STAT)
         d = {1'b0, raw, 1'b0, fl};
      else if (a >= ADDR_DCFG0 && a < ADDR_DEND)
         d = {26'h000_0000, st.dcfg[5'((a - ADDR_DCFG0) >> 2)]};
      return d;
   endfunction

   // ************************************************************
   // debounce filters, one per input
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < NFILT; g++)
      begin : g_filt
         // own setting per input, sampled after synchronising
         tbrd_filter #(
            .N_LONG (N_LONG)
         ) u_filt (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .sample_en (s_r.tick),
            .din       (s_r.sync2[g]),
            .setting   (s_r.fcfg[g]),
            .dout      (filt[g])
         );
      end
   endgenerate

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic [3:0] sel;  // destination line selector
      logic       lvl;  // destination polarised level
      logic       apen; // address phase accepted
      logic [7:0] a;    // pending write address
      sel   = 4'h0;
      lvl   = 1'b0;
      s_nxt = s_r;
      a     = s_r.wr_addr;
      apen  = hsel && hready && htrans[1];

      // pins pass two flops before anything reads them
      s_nxt.sync1 = {pfl_in, star_in, itb_in};
      s_nxt.sync2 = s_r.sync1;

      // sample tick; one per cycle while hclk is under 80 MHz
      if (s_r.div >= 8'(SAMPLE_DIV - 1))
      begin
         s_nxt.div  = 8'h00;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.div  = s_r.div + 8'h01;
         s_nxt.tick = 1'b0;
      end

      // write data phase; unmapped or unaligned writes vanish
      if (s_r.wr_pend && a[1:0] == 2'h0)
      begin
         if (a == ADDR_DIR)
            s_nxt.dir = hwdata[NBUS-1:0];
         else if (a >= ADDR_OSEL0 && a < ADDR_FCFG)
            s_nxt.osel[3'((a - ADDR_OSEL0) >> 2)] = hwdata[4:0];
         else if (a == ADDR_FCFG)
            s_nxt.fcfg = hwdata[2*NFILT-1:0];
         else if (a == ADDR_FSEL)
            s_nxt.fsel = hwdata[4*NFUNC-1:0];
         else if (a >= ADDR_DCFG0 && a < ADDR_DEND)
            s_nxt.dcfg[5'((a - ADDR_DCFG0) >> 2)] = hwdata[5:0];
      end

      // address phase: capture write, fetch read at once
      s_nxt.wr_pend = apen && hwrite;
      s_nxt.wr_addr = haddr[7:0];
      if (apen && !hwrite)
         s_nxt.rdata = rd_reg(haddr[7:0], s_nxt, filt, s_r.sync2);
      else
         s_nxt.rdata = 32'h0000_0000;

      // bus line drivers, shared with the backplane trigger lines
      for (int i = 0; i < NBUS; i++)
      begin
         s_nxt.bus_out[i] = src_pick(s_r.osel[i], int_src,
                                     s_r.sync2[NFILT-1:NBUS+1]);
         s_nxt.bus_oe[i]  = s_r.dir[i];
      end

      // function lines fed straight from a bus line, unfiltered
      for (int j = 0; j < NFUNC; j++)
      begin
         s_nxt.fn_oe[j]  = s_r.fsel[j][FS_EN];
         s_nxt.fn_out[j] = s_r.fsel[j][FS_EN] &&
                           s_r.sync2[3'(s_r.fsel[j][2:0])];
      end

      // timing destinations: 1..8 bus, 9 star, 10..15 function
      for (int d = 0; d < NDEST; d++)
      begin
         sel = s_r.dcfg[d][3:0];
         if (sel == DSEL_NONE)
            lvl = 1'b0;
         else
            lvl = filt[4'(sel - 4'h1)];
         lvl = lvl ^ s_r.dcfg[d][DC_INV];
         s_nxt.dlvl[d] = lvl;
         if (s_r.dcfg[d][DC_EDGE])
            s_nxt.dest[d] = lvl && !s_r.dlvl[d];
         else
            s_nxt.dest[d] = lvl;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   // all-zero reset: lines undriven, filters off, no routes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ************************************************************
   // outputs, each straight from a flop
   // ************************************************************
   // zero wait states and OKAY only, so these are reset constants
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata   = s_r.rdata;
   assign itb_out  = s_r.bus_out;
   assign itb_oe   = s_r.bus_oe;
   assign pfl_out  = s_r.fn_out;
   assign pfl_oe   = s_r.fn_oe;
   assign dest_out = s_r.dest;

endmodule // tbrd_top
`default_nettype wire
